// File: core/gdp_protect_cfg.v
// Purpose: Write-lockable gate-drive protection configuration and phase log
// Assumes: Avalon-MM slave, one fixed wait cycle per access; pins asynchronous
// Notes:   EXTENDED selects the extended variant field set
`timescale 1ns/100ps
`include "gdp_regs.vh"

module gdp_protect_cfg #(
    parameter EXTENDED = 1
) (
    clk,
    rst,
    avs_address,
    avs_read,
    avs_write,
    avs_writedata,
    avs_readdata,
    avs_waitrequest,
    desat_err,
    phase_status_bits,
    hs_desat_level,
    hs_desat_filter_sel,
    ls_desat_level,
    ls_desat_filter_sel,
    oc0_action_sel,
    oc0_comp_enable,
    oc0_dac_code,
    cp_enable,
    cp_clk,
    write_protect_lock,
    irq
);
    input  wire                   clk;
    input  wire                   rst;
    input  wire [`GDP_ADDR_W-1:0] avs_address;
    input  wire                   avs_read;
    input  wire                   avs_write;
    input  wire [31:0]            avs_writedata;
    output reg  [31:0]            avs_readdata;
    output reg                    avs_waitrequest;
    input  wire                   desat_err;
    input  wire [2:0]             phase_status_bits;
    output reg  [2:0]             hs_desat_level;
    output reg                    hs_desat_filter_sel;
    output reg  [2:0]             ls_desat_level;
    output reg                    ls_desat_filter_sel;
    output reg                    oc0_action_sel;
    output reg                    oc0_comp_enable;
    output reg  [5:0]             oc0_dac_code;
    output reg                    cp_enable;
    output wire                   cp_clk;
    output reg                    write_protect_lock;
    output reg                    irq;

    // ------------------------------------------------------------------------
    // Storage and bus state
    // ------------------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_ANS  = 2'b10;

    reg  [7:0] desat_q;
    reg  [2:0] phlog_q;
    reg  [3:0] cpdiv_q;
    reg  [7:0] oc0_q;
    reg        wp_q;
    reg        cpe_q;
    reg  [1:0] ist_q;
    reg  [1:0] ist_d;
    reg  [1:0] imsk_q;
    reg  [1:0] bus_st_q;
    reg  [1:0] bus_st_d;
    reg  [7:0] rd_d;
    reg  [7:0] desat_mask;
    reg  [7:0] oc0_mask;
    reg        desat_prev_q;
    wire       desat_s;
    wire       desat_evt;
    wire       wr_go;
    wire       req_new;
    wire [2:0] ph_s;
    wire [1:0] ist_set;
    wire [1:0] ist_clr;

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    gdp_sync2 u_sync_desat (
        .clk (clk),
        .rst (rst),
        .d   (desat_err),
        .q   (desat_s)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_ph
            gdp_sync2 u_sync_ph (
                .clk (clk),
                .rst (rst),
                .d   (phase_status_bits[gi]),
                .q   (ph_s[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Writable bit masks per variant
    // ------------------------------------------------------------------------
    always @* begin
        desat_mask = 8'h77;
        oc0_mask   = 8'hCF;
        if (EXTENDED != 0) begin
            desat_mask = 8'hFF;
            oc0_mask   = 8'hDF;
        end
    end

    // ------------------------------------------------------------------------
    // Avalon access: one wait cycle, answer on second edge
    // ------------------------------------------------------------------------
    assign wr_go   = avs_write && (bus_st_q == ST_ANS);
    assign req_new = (avs_read || avs_write) && (bus_st_q == ST_IDLE);

    always @* begin
        bus_st_d = bus_st_q;
        case (bus_st_q)
            ST_IDLE: begin
                if (req_new) begin
                    bus_st_d = ST_ANS;
                end
            end
            ST_ANS: begin
                bus_st_d = ST_IDLE;
            end
            default: begin
                bus_st_d = ST_IDLE;
            end
        endcase
    end

    always @* begin
        case (avs_address)
            `GDP_OFS_DESAT:    rd_d = desat_q & desat_mask;
            `GDP_OFS_PHLOG:    rd_d = {5'h00, phlog_q};
            `GDP_OFS_CPCLK:    rd_d = {4'h0, cpdiv_q};
            `GDP_OFS_OC0:      rd_d = oc0_q & oc0_mask;
            `GDP_OFS_CTRL:     rd_d = {6'h00, cpe_q, wp_q};
            `GDP_OFS_IRQ_STAT: rd_d = {6'h00, ist_q};
            `GDP_OFS_IRQ_MASK: rd_d = {6'h00, imsk_q};
            default:           rd_d = 8'h00;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_st_q        <= ST_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            bus_st_q        <= bus_st_d;
            avs_waitrequest <= !req_new;
            if (req_new) begin
                avs_readdata <= {24'h00_0000, rd_d};
            end
        end
    end

    // ------------------------------------------------------------------------
    // Configuration registers; DESAT, CPCLK and OC0 sit behind the write lock, CTRL and IRQ mask do not
    // ------------------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            desat_q <= `GDP_RST_DESAT;
        end else if (wr_go && avs_address == `GDP_OFS_DESAT && !wp_q) begin
            desat_q <= avs_writedata[7:0] & desat_mask;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cpdiv_q <= `GDP_RST_CPCLK;
        end else if (wr_go && avs_address == `GDP_OFS_CPCLK && !wp_q) begin
            cpdiv_q <= avs_writedata[3:0];
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            oc0_q <= `GDP_RST_OC0;
        end else if (wr_go && avs_address == `GDP_OFS_OC0 && !wp_q) begin
            oc0_q <= avs_writedata[7:0] & oc0_mask;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_q  <= 1'b0;
            cpe_q <= 1'b0;
        end else if (wr_go && avs_address == `GDP_OFS_CTRL) begin
            wp_q  <= wp_q | avs_writedata[`GDP_CTRL_WP_BIT];
            cpe_q <= avs_writedata[`GDP_CTRL_CPE_BIT];
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            imsk_q <= `GDP_RST_IRQ;
        end else if (wr_go && avs_address == `GDP_OFS_IRQ_MASK) begin
            imsk_q <= avs_writedata[1:0];
        end
    end

    // ------------------------------------------------------------------------
    // Event detection, phase log and interrupt status
    // ------------------------------------------------------------------------
    assign desat_evt = desat_s && !desat_prev_q;
    assign ist_set   = {1'b0, desat_evt};
    assign ist_clr   = (wr_go && avs_address == `GDP_OFS_IRQ_STAT) ?
                       avs_writedata[1:0] : 2'h0;

    always @* begin
        ist_d = (ist_q & ~ist_clr) | ist_set;
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            desat_prev_q <= 1'b0;
            phlog_q      <= `GDP_RST_PHLOG;
        end else begin
            desat_prev_q <= desat_s;
            if (desat_evt) begin
                phlog_q <= ph_s;
            end
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ist_q <= `GDP_RST_IRQ;
            irq   <= 1'b0;
        end else begin
            ist_q <= ist_d;
            irq   <= |(ist_d & imsk_q);
        end
    end

    // ------------------------------------------------------------------------
    // Outputs to the analog front end
    // ------------------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            hs_desat_level      <= 3'h0;
            hs_desat_filter_sel <= 1'b0;
            ls_desat_level      <= 3'h0;
            ls_desat_filter_sel <= 1'b0;
        end else begin
            hs_desat_level      <= desat_q[`GDP_HS_LVL_HI:`GDP_HS_LVL_LO];
            hs_desat_filter_sel <= desat_q[`GDP_HS_FILT_BIT];
            ls_desat_level      <= desat_q[`GDP_LS_LVL_HI:`GDP_LS_LVL_LO];
            ls_desat_filter_sel <= desat_q[`GDP_LS_FILT_BIT];
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            oc0_action_sel  <= 1'b0;
            oc0_comp_enable <= 1'b0;
            oc0_dac_code    <= 6'h00;
        end else begin
            oc0_action_sel  <= oc0_q[`GDP_OC_ACT_BIT];
            oc0_comp_enable <= oc0_q[`GDP_OC_EN_BIT];
            if (EXTENDED != 0) begin
                oc0_dac_code <= {`GDP_DAC_TOP_EXT, oc0_q[4:0]};
            end else begin
                oc0_dac_code <= {`GDP_DAC_TOP_RED, oc0_q[3:0]};
            end
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cp_enable          <= 1'b0;
            write_protect_lock <= 1'b0;
        end else begin
            cp_enable          <= cpe_q;
            write_protect_lock <= wp_q;
        end
    end

    // ------------------------------------------------------------------------
    // Charge-pump clock
    // ------------------------------------------------------------------------
    gdp_cp_clkdiv u_cp_div (
        .clk     (clk),
        .rst     (rst),
        .enable  (cpe_q),
        .div_sel (cpdiv_q),
        .cp_clk  (cp_clk)
    );
endmodule

// File: core/gdp_regs.vh
// Purpose: Register map, field positions, reset values and codes of the gate-drive config bank
// Assumes: Avalon-MM word addressing on byte offsets, 8-bit registers in low bits
// Notes:   Included by gdp_protect_cfg and gdp_cp_clkdiv (not gdp_sync2) and by the bench
`ifndef GDP_REGS_VH
`define GDP_REGS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define GDP_ADDR_W            6
`define GDP_OFS_DESAT         6'h00
`define GDP_OFS_PHLOG         6'h04
`define GDP_OFS_CPCLK         6'h08
`define GDP_OFS_OC0           6'h0C
`define GDP_OFS_CTRL          6'h10
`define GDP_OFS_IRQ_STAT      6'h14
`define GDP_OFS_IRQ_MASK      6'h18

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define GDP_HS_FILT_BIT       7
`define GDP_HS_LVL_HI         6
`define GDP_HS_LVL_LO         4
`define GDP_LS_FILT_BIT       3
`define GDP_LS_LVL_HI         2
`define GDP_LS_LVL_LO         0
`define GDP_OC_ACT_BIT        7
`define GDP_OC_EN_BIT         6
`define GDP_CTRL_WP_BIT       0
`define GDP_CTRL_CPE_BIT      1
`define GDP_IRQ_DESAT_BIT     0
`define GDP_IRQ_OC_BIT        1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define GDP_RST_DESAT         8'h00
`define GDP_RST_PHLOG         3'h0
`define GDP_RST_CPCLK         4'h0
`define GDP_RST_OC0           8'h00
`define GDP_RST_IRQ           2'h0

// ----------------------------------------------------------------------------
// Threshold converter and divider codes
// ----------------------------------------------------------------------------
`define GDP_DAC_TOP_RED       2'h3
`define GDP_DAC_TOP_EXT       1'h1
`define GDP_DIV_W             10

`endif

// File: core/gdp_sync2.v
// Purpose: Two-flop synchroniser for one asynchronous level
// Assumes: Single clock domain clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module gdp_sync2 (
    clk,
    rst,
    d,
    q
);
    input  wire clk;
    input  wire rst;
    input  wire d;
    output reg  q;

    reg meta_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// File: core/gdp_cp_clkdiv.v
// Purpose: Charge-pump clock divider with sixteen selectable factors
// Assumes: Divider code stable while enable is high
// Notes:   Output is a registered square wave, low while disabled
`timescale 1ns/100ps
`include "gdp_regs.vh"
module gdp_cp_clkdiv (
    clk,
    rst,
    enable,
    div_sel,
    cp_clk
);
    input  wire       clk;
    input  wire       rst;
    input  wire       enable;
    input  wire [3:0] div_sel;
    output reg        cp_clk;

    reg  [`GDP_DIV_W-1:0] cnt_q;
    reg  [`GDP_DIV_W-1:0] half_d;

    // ------------------------------------------------------------------------
    // Factor table, half period in bus clocks
    // ------------------------------------------------------------------------
    always @* begin
        case (div_sel)
            4'h0:    half_d = 10'd8;
            4'h1:    half_d = 10'd12;
            4'h2:    half_d = 10'd16;
            4'h3:    half_d = 10'd24;
            4'h4:    half_d = 10'd32;
            4'h5:    half_d = 10'd48;
            4'h6:    half_d = 10'd50;
            4'h7:    half_d = 10'd64;
            4'h8:    half_d = 10'd96;
            4'h9:    half_d = 10'd100;
            4'hA:    half_d = 10'd128;
            4'hB:    half_d = 10'd192;
            4'hC:    half_d = 10'd200;
            4'hD:    half_d = 10'd256;
            4'hE:    half_d = 10'd384;
            default: half_d = 10'd400;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q  <= {`GDP_DIV_W{1'b0}};
            cp_clk <= 1'b0;
        end else if (!enable) begin
            cnt_q  <= {`GDP_DIV_W{1'b0}};
            cp_clk <= 1'b0;
        end else if (cnt_q == half_d - 10'd1) begin
            cnt_q  <= {`GDP_DIV_W{1'b0}};
            cp_clk <= ~cp_clk;
        end else begin
            cnt_q  <= cnt_q + 10'd1;
        end
    end
endmodule

// File: sim/gdp_protect_cfg_assertions.sv
// Purpose: Bus, lock, threshold and pump clock checks
// Assumes: Sees only ports of gdp_protect_cfg
// Notes:   Attached by bind below
`timescale 1ns/100ps
module gdp_cfg_chk #(
    parameter EXTENDED = 1
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [2:0]  hs_desat_level,
    input wire logic        hs_desat_filter_sel,
    input wire logic [2:0]  ls_desat_level,
    input wire logic        ls_desat_filter_sel,
    input wire logic        oc0_action_sel,
    input wire logic        oc0_comp_enable,
    input wire logic [5:0]  oc0_dac_code,
    input wire logic        cp_enable,
    input wire logic        cp_clk,
    input wire logic        write_protect_lock
);
    // ----
    // Checks
    // ----
    wire [15:0] cfg = {hs_desat_level, hs_desat_filter_sel, ls_desat_level,
                       ls_desat_filter_sel, oc0_action_sel, oc0_comp_enable, oc0_dac_code};
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_wait_one_low: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_req_answered: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered");
    a_rdata_upper: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    a_lock_sticky: assert property (write_protect_lock |=> write_protect_lock)
        else $error("lock cleared without reset");
    a_lock_freeze: assert property ($past(write_protect_lock, 2) |-> $stable(cfg))
        else $error("locked config changed");
    a_dac_top: assert property (!$past(rst) && !$past(rst, 2) && !$past(rst, 3) |-> oc0_dac_code[5] && (EXTENDED != 0 || oc0_dac_code[4]))
        else $error("converter top bits wrong");
    a_cp_idle: assert property (!cp_enable && !$past(cp_enable) && !$past(cp_enable, 2) |-> !cp_clk)
        else $error("pump clock runs while off");
    a_cp_half: assert property ($rose(cp_clk) |-> cp_clk [*8])
        else $error("pump clock high too short");
    c_locked_write: cover property (write_protect_lock && avs_write && !avs_waitrequest);
    c_cp_rise: cover property ($rose(cp_clk));
    c_read_done: cover property (avs_read && !avs_waitrequest);
endmodule

bind gdp_protect_cfg gdp_cfg_chk #(.EXTENDED(EXTENDED)) u_chk (
    .clk(clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .hs_desat_level(hs_desat_level), .hs_desat_filter_sel(hs_desat_filter_sel),
    .ls_desat_level(ls_desat_level), .ls_desat_filter_sel(ls_desat_filter_sel),
    .oc0_action_sel(oc0_action_sel), .oc0_comp_enable(oc0_comp_enable),
    .oc0_dac_code(oc0_dac_code), .cp_enable(cp_enable), .cp_clk(cp_clk),
    .write_protect_lock(write_protect_lock)
);

// File: sim/gdp_protect_cfg_tb.sv
// Purpose: Self-checking bench of the gate-drive config bank
// Assumes: Extended variant as dut, reduced variant beside it on the same bus, 200 MHz
// Notes:   Scenario tasks run in turn from one initial block
`timescale 1ns/100ps
`include "gdp_regs.vh"
module gdp_protect_cfg_tb;
    reg         clk, rst, rd, wr, derr;
    reg  [5:0]  adr;
    reg  [31:0] wd;
    reg  [2:0]  ph;
    wire [31:0] rdat;
    wire [2:0]  hsl, lsl;
    wire [5:0]  dac;
    wire        wreq, hsf, lsf, oca, oce, cpe, cpc, wpl, irq;
    wire [31:0] rdat_r;
    wire [2:0]  hsl_r, lsl_r;
    wire [5:0]  dac_r;
    wire        hsf_r, lsf_r, oca_r, oce_r;
    int         fails, total_checks, cyc;
    int         fac [16] = '{16, 24, 32, 48, 64, 96, 100, 128, 192, 200, 256, 384, 400,
                              512, 768, 800};
    gdp_protect_cfg #(.EXTENDED(1)) dut (
        .clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wreq), .desat_err(derr),
        .phase_status_bits(ph), .hs_desat_level(hsl), .hs_desat_filter_sel(hsf),
        .ls_desat_level(lsl), .ls_desat_filter_sel(lsf), .oc0_action_sel(oca),
        .oc0_comp_enable(oce), .oc0_dac_code(dac), .cp_enable(cpe), .cp_clk(cpc),
        .write_protect_lock(wpl), .irq(irq)
    );
    gdp_protect_cfg #(.EXTENDED(0)) dut_red (
        .clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_readdata(rdat_r), .avs_waitrequest(), .desat_err(derr),
        .phase_status_bits(ph), .hs_desat_level(hsl_r), .hs_desat_filter_sel(hsf_r),
        .ls_desat_level(lsl_r), .ls_desat_filter_sel(lsf_r), .oc0_action_sel(oca_r),
        .oc0_comp_enable(oce_r), .oc0_dac_code(dac_r), .cp_enable(), .cp_clk(),
        .write_protect_lock(), .irq()
    );
    // ----
    // Clock, timeout and shared tasks
    // ----
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails = fails + 1;
            wrap_up;
        end
    end
    task wrap_up;
        begin
            if (fails == 0 && total_checks > 0) begin
                $display("ALL TESTS PASSED");
            end else begin
                $display("TESTS FAILED");
            end
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task bus(input w, input [5:0] a, input [7:0] d, output [31:0] q);
        int n;
        begin
            @(posedge clk);
            rd <= ~w;
            wr <= w;
            adr <= a;
            wd <= {24'h000000, d};
            n = 0;
            @(posedge clk);
            while (wreq !== 1'b0 && n < 20) begin
                @(posedge clk);
                n = n + 1;
            end
            if (wreq !== 1'b0) begin
                chk(wreq, 1'b0);
            end
            q = rdat;
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask
    task wr8(input [5:0] a, input [7:0] d);
        reg [31:0] q;
        begin
            bus(1'b1, a, d, q);
        end
    endtask
    task rdc(input [5:0] a, input [7:0] e);
        reg [31:0] q;
        begin
            bus(1'b0, a, 8'h00, q);
            chk(q, {24'h000000, e});
        end
    endtask
    task pins(input e, input [2:0] p);
        begin
            @(posedge clk);
            derr <= e;
            ph <= p;
            repeat (6) @(posedge clk);
        end
    endtask
    task wlev(input v, inout int n);
        begin
            while (cpc === v && n < 2000) begin
                @(posedge clk);
                n = n + 1;
            end
        end
    endtask
    // ----
    // Scenarios
    // ----
    task t_reset;
        int i;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                rdc(6'(i * 4), 8'h00);
            end
        end
    endtask
    task t_desat;
        reg [2:0] c;
        int i;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                c = i[2:0];
                wr8(`GDP_OFS_DESAT, {c[0], c, ~c[0], ~c});
                rdc(`GDP_OFS_DESAT, {c[0], c, ~c[0], ~c});
                chk({hsf, hsl, lsf, lsl}, {c[0], c, ~c[0], ~c});
                chk(rdat_r, {24'h000000, 1'b0, c, 1'b0, ~c});
                chk({hsf_r, hsl_r, lsf_r, lsl_r}, {1'b0, c, 1'b0, ~c});
            end
        end
    endtask
    task t_oc;
        reg [4:0] c;
        int i;
        begin
            for (i = 0; i < 32; i = i + 1) begin
                c = i[4:0];
                wr8(`GDP_OFS_OC0, {c[0], c[1], 1'b1, c});
                rdc(`GDP_OFS_OC0, {c[0], c[1], 1'b0, c});
                chk({oca, oce, dac}, {c[0], c[1], 1'b1, c});
                chk(rdat_r, {24'h000000, c[0], c[1], 2'h0, c[3:0]});
                chk({oca_r, oce_r, dac_r}, {c[0], c[1], 2'h3, c[3:0]});
            end
            wr8(`GDP_OFS_CPCLK, 8'hFF);
            rdc(`GDP_OFS_CPCLK, 8'h0F);
        end
    endtask
    task t_phase;
        begin
            wr8(`GDP_OFS_IRQ_MASK, 8'h01);
            pins(1'b0, 3'h5);
            pins(1'b1, 3'h5);
            rdc(`GDP_OFS_PHLOG, 8'h05);
            rdc(`GDP_OFS_IRQ_STAT, 8'h01);
            chk(irq, 1'b1);
            pins(1'b0, 3'h2);
            wr8(`GDP_OFS_PHLOG, 8'h07);
            rdc(`GDP_OFS_PHLOG, 8'h05);
            rdc(`GDP_OFS_PHLOG, 8'h05);
            wr8(`GDP_OFS_IRQ_STAT, 8'h01);
            wr8(`GDP_OFS_IRQ_MASK, 8'h00);
            pins(1'b1, 3'h2);
            rdc(`GDP_OFS_PHLOG, 8'h02);
            chk(irq, 1'b0);
            wr8(`GDP_OFS_IRQ_MASK, 8'h01);
            rdc(`GDP_OFS_IRQ_STAT, 8'h01);
            chk(irq, 1'b1);
            wr8(`GDP_OFS_IRQ_STAT, 8'h01);
            rdc(`GDP_OFS_IRQ_STAT, 8'h00);
            chk(irq, 1'b0);
            pins(1'b0, 3'h2);
        end
    endtask
    task t_cp;
        int i, n;
        begin
            for (i = 0; i < 16; i = i + 1) begin
                wr8(`GDP_OFS_CTRL, 8'h00);
                wr8(`GDP_OFS_CPCLK, i[7:0]);
                wr8(`GDP_OFS_CTRL, 8'h02);
                n = 0;
                wlev(1'b0, n);
                n = 0;
                wlev(1'b1, n);
                wlev(1'b0, n);
                chk(n, fac[i]);
                chk(cpe, 1'b1);
                wlev(1'b1, n);
            end
            wr8(`GDP_OFS_CTRL, 8'h00);
        end
    endtask
    task t_lock;
        begin
            wr8(`GDP_OFS_DESAT, 8'h11);
            wr8(`GDP_OFS_CPCLK, 8'h03);
            wr8(`GDP_OFS_OC0, 8'h42);
            wr8(`GDP_OFS_CTRL, 8'h01);
            wr8(`GDP_OFS_DESAT, 8'hEE);
            wr8(`GDP_OFS_CPCLK, 8'h0C);
            wr8(`GDP_OFS_OC0, 8'h9D);
            wr8(`GDP_OFS_CTRL, 8'h02);
            rdc(`GDP_OFS_DESAT, 8'h11);
            rdc(`GDP_OFS_CPCLK, 8'h03);
            rdc(`GDP_OFS_OC0, 8'h42);
            rdc(`GDP_OFS_CTRL, 8'h03);
            chk({wpl, hsf, hsl, lsf, lsl, oca, oce, dac}, {1'b1, 8'h11, 8'h62});
        end
    endtask
    task t_rst2;
        begin
            @(posedge clk);
            rst <= 1'b1;
            repeat (10) @(posedge clk);
            rst <= 1'b0;
            rdc(`GDP_OFS_PHLOG, 8'h00);
            rdc(`GDP_OFS_CTRL, 8'h00);
            wr8(`GDP_OFS_DESAT, 8'h5A);
            rdc(`GDP_OFS_DESAT, 8'h5A);
        end
    endtask
    initial begin
        rst = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        derr = 1'b0;
        adr = 6'h00;
        wd = 32'h00000000;
        ph = 3'h0;
        repeat (10) @(posedge clk);
        chk({hsl, hsf, lsl, lsf, oca, oce, dac, cpe, cpc, wpl, irq}, 32'h0);
        rst <= 1'b0;
        t_reset;
        t_desat;
        t_oc;
        t_phase;
        t_cp;
        t_lock;
        t_rst2;
        wrap_up;
    end
endmodule
